// *** shared/pwr_seq_pkg.sv ***
// Shared constants for the power request sequencer, both ends
package pwr_seq_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Clock
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;            // Module clock rate
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;      // Cycles in one millisecond

  // ****************************************
  // Times as printed, in milliseconds
  // ****************************************
  localparam int unsigned DETECT_MS = 250;                 // Request ignored after supply appears
  localparam int unsigned MIN_LOW_MS = 685;                // Least low time to power on
  localparam int unsigned PULSE_MS = 135;                  // Early ready pulse
  localparam int unsigned IRST_MS = 38;                    // Internal reset during power-on
  localparam int unsigned READY_MS = 5000;                 // Ready rises, typical
  localparam int unsigned READY_MAX_MS = 7000;             // Ready rises, latest
  localparam int unsigned HARD_OFF_MS = 5500;              // Low pulse for hardware power-off

  // ****************************************
  // Derived cycle counts (all above 4096, so modules expose them)
  // ****************************************
  localparam int unsigned DETECT_CYC = DETECT_MS * CYC_PER_MS;
  localparam int unsigned MIN_LOW_CYC = MIN_LOW_MS * CYC_PER_MS;
  localparam int unsigned PULSE_CYC = PULSE_MS * CYC_PER_MS;
  localparam int unsigned IRST_CYC = IRST_MS * CYC_PER_MS;
  localparam int unsigned READY_CYC = READY_MS * CYC_PER_MS;
  localparam int unsigned READY_MAX_CYC = READY_MAX_MS * CYC_PER_MS;
  localparam int unsigned HARD_OFF_CYC = HARD_OFF_MS * CYC_PER_MS;

  // ****************************************
  // Reset values and widths
  // ****************************************
  localparam int unsigned CNT_W = 32;                      // Width of every timer
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0;            // Timer reset value

  // Device states, Gray along the power-on and power-off path
  typedef enum logic [2:0] {
    DEV_SETTLE = 3'h0,
    DEV_IDLE = 3'h1,
    DEV_START = 3'h3,
    DEV_BOOT = 3'h2,
    DEV_ON = 3'h6,
    DEV_DEREG = 3'h7,
    DEV_CHECK = 3'h5
  } dev_state_t;

  // Host states, Gray from HST_IDLE to HST_OFFWAIT, but not on the return to HST_IDLE
  typedef enum logic [2:0] {
    HST_IDLE = 3'h0,
    HST_LOWMIN = 3'h1,
    HST_LOWWAIT = 3'h3,
    HST_UP = 3'h2,
    HST_OFFLOW = 3'h6,
    HST_OFFWAIT = 3'h7
  } hst_state_t;

endpackage : pwr_seq_pkg

// *** shared/pwr_link_if.sv ***
// Link between the host and the module: power request line, ready and reset
interface pwr_link_if;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Wires of the link
  // ****************************************
  logic reqOut;       // Host value on the request pin (always low)
  logic reqOe;        // Host drives the request pin
  logic devPullUp;    // Module pull-up active
  logic powerReqN;    // Resolved request level, active low
  logic moduleReady;  // Ready indication from the module
  logic extResetN;    // Emergency reset from the host, active low

  // Open-collector line: low while host drives, else pulled up if supplied
  assign powerReqN = reqOe ? reqOut : devPullUp;

  // ****************************************
  // Views for each party
  // ****************************************
  modport dev (
    input powerReqN,
    output devPullUp,
    output moduleReady
  );

  modport host (
    input moduleReady,
    output reqOut,
    output reqOe,
    output extResetN
  );

endinterface : pwr_link_if

// *** design/module_power_seq.sv ***
// Module end of the power sequencer: request detect, power-on, power-off
// What this block does
// - Pull request line high once supplied
// - Only a low request starts power-on
// - Ignore request for 250 ms after supply
// - Host holds request low at least 685 ms
// - Ready pulses high 135 ms early on
// - Internal reset 38 ms; host avoids reset
// - Ready rises about 5 s after request
// - Host may hold request low while powered
// - Host releases after pulse and ready rise
// - Accept soft power-off command
// - Soft command ignored while request low
// - 5.5 s low pulse issues internal command
// - Deregister from network before shutdown
// - Ready low during power-off processing
// - Switch off only if request is high
// - Ready low before power-off, except on supply loss
module module_power_seq
  import pwr_seq_pkg::*;
#(
  parameter int unsigned DetectCycles = DETECT_CYC,
  parameter int unsigned MinLowCycles = MIN_LOW_CYC,
  parameter int unsigned PulseCycles = PULSE_CYC,
  parameter int unsigned IrstCycles = IRST_CYC,
  parameter int unsigned ReadyCycles = READY_CYC,
  parameter int unsigned HardOffCycles = HARD_OFF_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link to the host
  pwr_link_if.dev link,
  // Module-side user signals
  input wire logic batteryPresent,
  input wire logic softPowerOffCmd,
  input wire logic deregDone,
  output logic poweredOn,
  output logic internalReset,
  output logic deregReq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Synchronisers for pin inputs
  // ****************************************
  logic reqMeta_q;    // First stage, read only by the second
  logic reqSync_q;    // Request level, active low
  logic batMeta_q;    // First stage, read only by the second
  logic batSync_q;    // Supply present

  // Two flops on every asynchronous pin
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqMeta_q <= 1'b1;
      reqSync_q <= 1'b1;
      batMeta_q <= 1'b0;
      batSync_q <= 1'b0;
    end
    else
    begin
      reqMeta_q <= link.powerReqN;
      reqSync_q <= reqMeta_q;
      batMeta_q <= batteryPresent;
      batSync_q <= batMeta_q;
    end
  end

  // Request asserted when line is low
  logic reqLow;
  assign reqLow = ~reqSync_q;

  // ****************************************
  // Sequencer state
  // ****************************************
  dev_state_t state_q, state_d;    // Main sequence
  logic [CNT_W-1:0] cnt_q, cnt_d;  // Shared timer
  logic armed_q, armed_d;          // Request seen high while on
  logic ready_q, ready_d;          // Ready indication
  logic pull_q, pull_d;            // Pull-up enable
  logic on_q, on_d;                // Powered flag
  logic irst_q, irst_d;            // Internal reset
  logic dereg_q, dereg_d;          // Deregistration pulse

  // Next-state logic
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    armed_d = armed_q;
    unique case (state_q)
      // Supply settling: request not looked at
      DEV_SETTLE:
      begin
        if (cnt_q >= DetectCycles - 1)
        begin
          state_d = DEV_IDLE;
          cnt_d = CNT_RST;
        end
        else
        begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      // Off, waiting for a low request
      DEV_IDLE:
      begin
        if (reqLow)
        begin
          state_d = DEV_START;
          cnt_d = CNT_RST;
        end
      end
      // Request low, minimum time running
      DEV_START:
      begin
        if (!reqLow)
        begin
          state_d = DEV_IDLE;
          cnt_d = CNT_RST;
        end
        else if (cnt_q >= MinLowCycles - 1)
        begin
          state_d = DEV_BOOT;
          cnt_d = cnt_q + 32'h1;
        end
        else
        begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      // Booting; timer keeps counting from the request
      DEV_BOOT:
      begin
        if (cnt_q >= ReadyCycles - 1)
        begin
          state_d = DEV_ON;
          cnt_d = CNT_RST;
          armed_d = 1'b0;
        end
        else
        begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      // Powered: watch soft command and long low pulse
      DEV_ON:
      begin
        // held low from power-on is not an off pulse
        if (!reqLow)
        begin
          armed_d = 1'b1;
          cnt_d = CNT_RST;
        end
        else if (armed_q)
        begin
          cnt_d = cnt_q + 32'h1;
        end
        // long low pulse is an internal command
        if (armed_q && reqLow && cnt_q >= HardOffCycles - 1)
        begin
          state_d = DEV_DEREG;
          cnt_d = CNT_RST;
        end
        // soft command accepted; not while low
        else if (softPowerOffCmd && !reqLow)
        begin
          state_d = DEV_DEREG;
          cnt_d = CNT_RST;
        end
      end
      DEV_DEREG:
      begin
        if (deregDone)
        begin
          state_d = DEV_CHECK;
        end
      end
      // switch off only with request high
      DEV_CHECK:
      begin
        if (!reqLow)
        begin
          state_d = DEV_IDLE;
        end
      end
      // Illegal code: recover to the settle phase
      default:
      begin
        state_d = DEV_SETTLE;
        cnt_d = CNT_RST;
      end
    endcase
    // Loss of supply drops everything, whatever the state
    if (!batSync_q)
    begin
      state_d = DEV_SETTLE;
      cnt_d = CNT_RST;
      armed_d = 1'b0;
    end
  end

  // Outputs derived from the next values, so each leaves a flop
  always_comb
  begin
    pull_d = batSync_q;
    // early pulse; ready when on; keep it low off the on state
    ready_d = (state_d == DEV_ON) || (state_d == DEV_START && cnt_d < PulseCycles);
    // internal reset at start of power-on
    irst_d = (state_d == DEV_START) && (cnt_d < IrstCycles);
    // Still powered until the final check lets go
    on_d = (state_d == DEV_START) || (state_d == DEV_BOOT) || (state_d == DEV_ON) ||
           (state_d == DEV_DEREG) || (state_d == DEV_CHECK);
    dereg_d = (state_q == DEV_ON) && (state_d == DEV_DEREG);
  end

  // Register the sequencer
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= DEV_SETTLE;
      cnt_q <= CNT_RST;
      armed_q <= 1'b0;
      ready_q <= 1'b0;
      pull_q <= 1'b0;
      on_q <= 1'b0;
      irst_q <= 1'b0;
      dereg_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      ready_q <= ready_d;
      pull_q <= pull_d;
      on_q <= on_d;
      irst_q <= irst_d;
      dereg_q <= dereg_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output straight from a flop
  assign link.devPullUp = pull_q;
  assign link.moduleReady = ready_q;
  assign poweredOn = on_q;
  assign internalReset = irst_q;
  assign deregReq = dereg_q;

endmodule // module_power_seq

// *** design/host_power_ctrl.sv ***
// Host end: drives the open-collector request line and watches ready
module host_power_ctrl
  import pwr_seq_pkg::*;
#(
  parameter int unsigned MinLowCycles = MIN_LOW_CYC,
  parameter int unsigned ReadyMaxCycles = READY_MAX_CYC,
  parameter int unsigned HardOffCycles = HARD_OFF_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link to the module
  pwr_link_if.host link,
  // Host user side
  input wire logic powerOnReq,
  input wire logic powerOffReq,
  input wire logic resetReq,
  output logic deviceUp,
  output logic busy,
  output logic failed
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Ready synchroniser
  // ****************************************
  logic rdyMeta_q;   // First stage, read only by the second
  logic rdySync_q;   // Ready level

  // Two flops on the ready pin
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdyMeta_q <= 1'b0;
      rdySync_q <= 1'b0;
    end
    else
    begin
      rdyMeta_q <= link.moduleReady;
      rdySync_q <= rdyMeta_q;
    end
  end

  // ****************************************
  // Host sequence
  // ****************************************
  hst_state_t state_q, state_d;    // Host sequence
  logic [CNT_W-1:0] cnt_q, cnt_d;  // Low-time timer
  logic seen_q, seen_d;            // Early pulse observed
  logic oe_q, oe_d;                // Pull request line low
  logic up_q, up_d;                // Module known up
  logic fail_q, fail_d;            // Last power-on timed out
  logic rst_q, rst_d;              // Reset drive, active low

  // Next-state logic
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    seen_d = seen_q;
    fail_d = fail_q;
    unique case (state_q)
      // Line released, waiting for a user request
      HST_IDLE:
      begin
        if (powerOnReq)
        begin
          state_d = HST_LOWMIN;
          cnt_d = CNT_RST;
          seen_d = 1'b0;
          fail_d = 1'b0;
        end
      end
      HST_LOWMIN:
      begin
        cnt_d = cnt_q + 32'h1;
        if (rdySync_q)
        begin
          seen_d = 1'b1;
        end
        if (cnt_q >= MinLowCycles - 1)
        begin
          state_d = HST_LOWWAIT;
        end
      end
      // keep low until ready rises again
      HST_LOWWAIT:
      begin
        cnt_d = cnt_q + 32'h1;
        if (rdySync_q && seen_q)
        begin
          state_d = HST_UP;
        end
        // Give up past the latest ready time
        else if (cnt_q >= ReadyMaxCycles - 1)
        begin
          state_d = HST_IDLE;
          fail_d = 1'b1;
        end
      end
      // Module up, line released
      HST_UP:
      begin
        if (powerOffReq)
        begin
          state_d = HST_OFFLOW;
          cnt_d = CNT_RST;
        end
        else if (!rdySync_q)
        begin
          state_d = HST_IDLE;
        end
      end
      HST_OFFLOW:
      begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= HardOffCycles - 1)
        begin
          state_d = HST_OFFWAIT;
        end
      end
      // Line released so the module may switch off
      HST_OFFWAIT:
      begin
        if (!rdySync_q)
        begin
          state_d = HST_IDLE;
        end
      end
      // Illegal code
      default:
      begin
        state_d = HST_IDLE;
      end
    endcase
  end

  // Outputs from next values
  always_comb
  begin
    oe_d = (state_d == HST_LOWMIN) || (state_d == HST_LOWWAIT) || (state_d == HST_OFFLOW);
    up_d = (state_d == HST_UP);
    // reset only once fully up, never during internal reset
    rst_d = !(resetReq && state_d == HST_UP);
  end

  // Register the host sequence
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= HST_IDLE;
      cnt_q <= CNT_RST;
      seen_q <= 1'b0;
      oe_q <= 1'b0;
      up_q <= 1'b0;
      fail_q <= 1'b0;
      rst_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      seen_q <= seen_d;
      oe_q <= oe_d;
      up_q <= up_d;
      fail_q <= fail_d;
      rst_q <= rst_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open collector only ever pulls low
  assign link.reqOut = 1'b0;
  assign link.reqOe = oe_q;
  assign link.extResetN = rst_q;
  assign deviceUp = up_q;
  assign busy = oe_q;
  assign failed = fail_q;

endmodule // host_power_ctrl

// *** verif/pwr_link_chk.sv ***
// Checker watching the power request link between host and module ends
module pwr_link_chk
  import pwr_seq_pkg::*;
#(
  parameter int unsigned PulseCycles = 10,
  parameter int unsigned MinLowCycles = 40,
  parameter int unsigned ReadyCycles = 100,
  parameter int unsigned HardOffCycles = 60
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link signals
  input wire logic reqOut,
  input wire logic reqOe,
  input wire logic devPullUp,
  input wire logic powerReqN,
  input wire logic moduleReady,
  input wire logic extResetN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Helper state
  // ********
  logic [CNT_W-1:0] readyRun_q, readyRun_d; // Cycles ready has been high
  logic [CNT_W-1:0] reqRun_q, reqRun_d; // Cycles host has pulled low
  logic [CNT_W-1:0] sinceRise_q, sinceRise_d; // Cycles since ready last rose
  logic readyPrev_q, offPulse_q, offPulse_d, pulseSeen_q, pulseSeen_d; // Flags
  logic riseNow; // Ready rising this cycle

  // Next values; an off pulse is a pull-down begun while ready is high
  always_comb
  begin
    riseNow = moduleReady && !readyPrev_q;
    readyRun_d = moduleReady ? readyRun_q + 32'h1 : '0;
    reqRun_d = reqOe ? reqRun_q + 32'h1 : '0;
    sinceRise_d = riseNow ? '0 : sinceRise_q + 32'h1;
    offPulse_d = !reqOe ? 1'b0 : ((reqRun_q == '0 && moduleReady) ? 1'b1 : offPulse_q);
    // Supply loss forgets an early pulse, so a later attempt starts clean
    pulseSeen_d = (riseNow || !devPullUp) ? 1'b0 :
                  ((!moduleReady && readyPrev_q && readyRun_q == PulseCycles) ? 1'b1 : pulseSeen_q);
  end

  // Registers only
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      readyRun_q <= '0;
      reqRun_q <= '0;
      sinceRise_q <= '0;
      readyPrev_q <= 1'b0;
      offPulse_q <= 1'b0;
      pulseSeen_q <= 1'b0;
    end
    else
    begin
      readyRun_q <= readyRun_d;
      reqRun_q <= reqRun_d;
      sinceRise_q <= sinceRise_d;
      readyPrev_q <= moduleReady;
      offPulse_q <= offPulse_d;
      pulseSeen_q <= pulseSeen_d;
    end
  end

  // ********
  // Assertions
  // ********
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence earlyFall;
    $fell(moduleReady) && readyRun_q < MinLowCycles;
  endsequence
  sequence onRise;
    $rose(moduleReady) && pulseSeen_q;
  endsequence
  sequence offRelease;
    $fell(reqOe) && offPulse_q;
  endsequence

  pulse_len_a: assert property (earlyFall |-> readyRun_q == PulseCycles)
    else $error("early ready pulse has wrong length");
  rise_cause_a: assert property ($rose(moduleReady) |-> $past(powerReqN, 3) == 1'b0)
    else $error("ready rose without a low request");
  ready_time_a: assert property (onRise |-> sinceRise_q >= ReadyCycles - 1 && sinceRise_q <= ReadyCycles + 1)
    else $error("ready rise out of time after pulse");
  min_low_a: assert property ($fell(reqOe) |-> reqRun_q >= MinLowCycles)
    else $error("host released request too soon");
  hard_len_a: assert property (offRelease |-> reqRun_q == HardOffCycles)
    else $error("off pulse has wrong length");
  hard_ready_a: assert property (offRelease |-> ##[0:6] !moduleReady)
    else $error("ready still high after off pulse");
  supply_ready_a: assert property (!devPullUp |-> ##[0:1] !moduleReady)
    else $error("ready high without supply");
  reset_quiet_a: assert property (reqOe |-> extResetN)
    else $error("external reset during request");
  pull_low_a: assert property (reqOe |-> !reqOut && !powerReqN)
    else $error("driven request line not low");
endmodule // pwr_link_chk

// *** verif/tb_top.sv ***
// Testbench joining host and module ends, plus a spare module driven directly
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_seq_pkg::*;

  // ********
  // Shortened counts
  // ********
  localparam int unsigned TDet = 20;
  localparam int unsigned TMin = 40;
  localparam int unsigned TPul = 10;
  localparam int unsigned TIrst = 4;
  localparam int unsigned TRdy = 100;
  localparam int unsigned THard = 60;

  logic mclk, arst_n; // Clock and reset
  logic batteryPresent, softPowerOffCmd, deregDone; // Module inputs
  logic poweredOn, internalReset, deregReq, poweredOnB; // Module outputs
  logic deregReqB, deregDoneB; // Spare module network handshake
  logic powerOnReq, powerOffReq, resetReq; // Host inputs
  logic deviceUp, busy, failed; // Host outputs
  int err_count, compares; // Bench counters
  int cycles = 0, irstCnt = 0, deregCnt = 0; // Counted on the clock only

  pwr_link_if link();
  pwr_link_if link2(); // Spare link, host side driven by the bench

  module_power_seq #(.DetectCycles(TDet), .MinLowCycles(TMin), .PulseCycles(TPul), .IrstCycles(TIrst),
    .ReadyCycles(TRdy), .HardOffCycles(THard)) u_module_power_seq (.mclk(mclk), .arst_n(arst_n),
    .link(link), .batteryPresent(batteryPresent), .softPowerOffCmd(softPowerOffCmd), .deregDone(deregDone),
    .poweredOn(poweredOn), .internalReset(internalReset), .deregReq(deregReq));
  module_power_seq #(.DetectCycles(TDet), .MinLowCycles(TMin), .PulseCycles(TPul), .IrstCycles(TIrst),
    .ReadyCycles(TRdy), .HardOffCycles(THard)) u_module_power_seq_b (.mclk(mclk), .arst_n(arst_n),
    .link(link2), .batteryPresent(batteryPresent), .softPowerOffCmd(1'b0), .deregDone(deregDoneB),
    .poweredOn(poweredOnB), .internalReset(), .deregReq(deregReqB));
  host_power_ctrl #(.MinLowCycles(TMin), .ReadyMaxCycles(150), .HardOffCycles(THard)) u_host_power_ctrl (
    .mclk(mclk), .arst_n(arst_n), .link(link), .powerOnReq(powerOnReq), .powerOffReq(powerOffReq),
    .resetReq(resetReq), .deviceUp(deviceUp), .busy(busy), .failed(failed));
  pwr_link_chk #(.PulseCycles(TPul), .MinLowCycles(TMin), .ReadyCycles(TRdy), .HardOffCycles(THard))
    u_pwr_link_chk (.mclk(mclk), .arst_n(arst_n), .reqOut(link.reqOut), .reqOe(link.reqOe),
    .devPullUp(link.devPullUp), .powerReqN(link.powerReqN), .moduleReady(link.moduleReady),
    .extResetN(link.extResetN));

  // Free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog, event counts and the network acknowledge
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (internalReset === 1'b1)
      irstCnt <= irstCnt + 1;
    if (deregReq === 1'b1)
      deregCnt <= deregCnt + 1;
    deregDone <= #1 deregReq;
    deregDoneB <= #1 deregReqB;
    // Ceiling well above the expected run of about a thousand cycles
    if (cycles == 3000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle pulse on the host power-on request input
  task automatic hostOn();
    powerOnReq = 1'b1;
    step(1);
    powerOnReq = 1'b0;
  endtask

  task automatic waitUp();
    for (int i = 0; i < 300 && deviceUp !== 1'b1; i++)
      step(1);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial
  begin
    err_count = 0;
    compares = 0;
    arst_n = 1'b0;
    batteryPresent = 1'b0;
    softPowerOffCmd = 1'b0;
    powerOnReq = 1'b0;
    powerOffReq = 1'b0;
    resetReq = 1'b0;
    link2.reqOe = 1'b0;
    link2.reqOut = 1'b0;
    link2.extResetN = 1'b1;
    step(4);
    arst_n = 1'b1;
    step(2);
    check("pullup unsupplied", link.devPullUp, 1'b0);
    batteryPresent = 1'b1;
    step(5);
    check("pullup supplied", link.devPullUp, 1'b1);
    check("line idle", link.powerReqN, 1'b1);
    // Request during the settle time is held off
    hostOn();
    step(TDet / 2);
    check("ready in settle", link.moduleReady, 1'b0);
    check("powered in settle", poweredOn, 1'b0);
    waitUp();
    check("device up", deviceUp, 1'b1);
    check("ready on", link.moduleReady, 1'b1);
    check("powered on", poweredOn, 1'b1);
    check("line released", busy, 1'b0);
    check("internal reset", irstCnt, TIrst);
    resetReq = 1'b1;
    step(2);
    check("ext reset", link.extResetN, 1'b0);
    resetReq = 1'b0;
    step(2);
    // Hardware off; soft command refused while the line is low
    powerOffReq = 1'b1;
    step(1);
    powerOffReq = 1'b0;
    step(10);
    softPowerOffCmd = 1'b1;
    step(1);
    softPowerOffCmd = 1'b0;
    step(1);
    check("ready line low", link.moduleReady, 1'b1);
    check("dereg line low", deregCnt, 0);
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      step(1);
    step(10);
    check("hard dereg", deregCnt, 1);
    check("hard ready", link.moduleReady, 1'b0);
    check("hard off", poweredOn, 1'b0);
    check("host down", deviceUp, 1'b0);
    // Soft off with the line high
    hostOn();
    waitUp();
    step(60);
    softPowerOffCmd = 1'b1;
    step(1);
    softPowerOffCmd = 1'b0;
    check("soft dereg", deregReq, 1'b1);
    check("soft ready", link.moduleReady, 1'b0);
    step(6);
    check("soft off", poweredOn, 1'b0);
    check("soft count", deregCnt, 2);
    // Supply lost mid-boot, host gives up
    hostOn();
    step(70);
    batteryPresent = 1'b0;
    for (int i = 0; i < 200 && failed !== 1'b1; i++)
      step(1);
    check("host failed", failed, 1'b1);
    check("no supply off", poweredOn, 1'b0);
    batteryPresent = 1'b1;
    step(TDet + 10);
    // Spare link: short request abandoned, then a held one succeeds
    link2.reqOe = 1'b1;
    step(TMin / 2);
    link2.reqOe = 1'b0;
    step(TRdy + 20);
    check("short powered", poweredOnB, 1'b0);
    check("short ready", link2.moduleReady, 1'b0);
    link2.reqOe = 1'b1;
    step(TRdy + 10);
    check("held powered", poweredOnB, 1'b1);
    check("held ready", link2.moduleReady, 1'b1);
    // Held low since power-on: never counted as an off pulse
    step(THard + 10);
    check("held long", poweredOnB, 1'b1);
    // Release, then a long low pulse still held at the end
    link2.reqOe = 1'b0;
    step(5);
    link2.reqOe = 1'b1;
    step(THard + 10);
    check("low off ready", link2.moduleReady, 1'b0);
    check("low still on", poweredOnB, 1'b1);
    link2.reqOe = 1'b0;
    step(6);
    check("released off", poweredOnB, 1'b0);
    end_sim();
  end
endmodule // tb_top
